/* inc/swdt_defs.svh */
// Purpose: Register map, field positions, reset values and timing of the watchdog
// Assumes: 100 MHz pclk, byte addresses on an 8-bit APB address
// Notes:   Definitions only
`ifndef SWDT_DEFS_SVH
`define SWDT_DEFS_SVH

// Register byte offsets
`define SWDT_A_CTRL   8'h00
`define SWDT_A_TMO    8'h04
`define SWDT_A_KICK   8'h08
`define SWDT_A_LEFT   8'h0C
`define SWDT_A_FAULT  8'h10
`define SWDT_A_CARRY  8'h14
`define SWDT_A_ERRCNT 8'h18
`define SWDT_A_ISTS   8'h1C
`define SWDT_A_IMASK  8'h20

// Field positions
`define SWDT_EN_BIT    0
`define SWDT_FAULT_BIT 2
`define SWDT_CARRY_BIT 2
`define SWDT_IRQ_BARK  0
`define SWDT_IRQ_CARRY 1

// Reset values and limits
`define SWDT_EN_RST    1'b1
`define SWDT_TMO_RST   8'hFF
`define SWDT_MASK_RST  2'h0
`define SWDT_TMO_MIN   8'h01
`define SWDT_ERR_MAX   4'hF

// Timing: one second in ns, clock period in ns, bark pulse length in cycles
`define SWDT_SEC_NS    1_000_000_000
`define SWDT_CLK_NS    10
`define SWDT_SEC_CYC   (`SWDT_SEC_NS / `SWDT_CLK_NS)
`define SWDT_BARK_CYC  8

`endif

/* inc/swdt_pkg.sv */
// Purpose: Types shared by the watchdog design files
// Assumes: Nothing beyond the defs header
// Notes:   Gray coded along idle, count, bark
package swdt_pkg;

  // Countdown controller states
  typedef enum logic [1:0] {
    SWDT_IDLE  = 2'b00,
    SWDT_COUNT = 2'b01,
    SWDT_BARK  = 2'b11
  } swdt_state_t;

endpackage : swdt_pkg

/* logic/swdt_secdiv.sv */
// Purpose: Seconds prescaler, one-cycle tick every CYC clocks
// Assumes: Single pclk domain
// Notes:   Restart holds the count at zero so a full second follows it
`timescale 1ns/100ps
module swdt_secdiv #(
  parameter int unsigned CYC = 100_000_000
) (
  input  wire logic pclk,     // System clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic restart,  // Hold count at zero
  output logic      tick_r    // One-cycle second pulse
);

  localparam int unsigned CW = (CYC < 2) ? 1 : $clog2(CYC);

  logic [CW-1:0] cnt_r;
  wire           last_w = (cnt_r == CW'(CYC - 1));

  // Refuse a prescale the counter cannot serve
  if (CYC < 2) begin : g_chk
    $error("swdt_secdiv: CYC must be at least 2");
  end

  // Free count, wrapped at the end of each second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= (restart | last_w) ? '0 : cnt_r + 1'b1;
      tick_r <= last_w & ~restart;
    end
  end

endmodule : swdt_secdiv

/* logic/swdt_top.sv */
// Purpose: System watchdog with APB registers, bark reset and error flags
// Assumes: pclk at 100 MHz, asynchronous active-low presetn
// Notes:   Single clock; the seconds rate is an enable from swdt_secdiv
//
// What this block does
// - Enable starts countdown, disable prevents any bark
// - Timeout is 1 to 255 whole seconds
// - Missing kick before timeout barks, resets system
// - Watchdog comes out of reset enabled
// - Any write to kick register kicks
// - Bark sets sticky reset-seen flag, write-one clears
// - Bark counts four-bit errors; wrap sets carry
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
`include "swdt_defs.svh"
module swdt_top
  import swdt_pkg::*;
#(
  parameter int unsigned SEC_CYC = `SWDT_SEC_CYC
) (
  input  wire logic        pclk,     // APB clock, 100 MHz
  input  wire logic        presetn,  // APB reset, active low
  input  wire logic [7:0]  paddr,    // Byte address
  input  wire logic        psel,     // Slave select
  input  wire logic        penable,  // Access phase
  input  wire logic        pwrite,   // Write when high
  input  wire logic [31:0] pwdata,   // Write data
  output logic      [31:0] prdata,   // Read data
  output logic             pready,   // Transfer done
  output logic             pslverr,  // Unmapped address
  output logic             irq,      // Level interrupt
  output logic             wdt_reset // Bark: system reset request
);

  swdt_state_t state_r, state_nxt;
  logic        en_r;
  logic [7:0]  tmo_r;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [2:0]  blen_r, blen_nxt;
  logic        fault_r;
  logic        carry_r;
  logic [3:0]  errcnt_r;
  logic [1:0]  ists_r;
  logic [1:0]  mask_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        irq_r;
  logic        bark_r;
  logic        tick;
  logic [31:0] rdata_w;

  // Bus phases: read data are sampled in the first access cycle, writes land on the edge that ends pready
  wire access_w = psel & penable;
  wire first_w  = access_w & ~pready_r;
  wire done_w   = access_w & pready_r;
  wire wr_w     = done_w & pwrite;
  wire rd_w     = done_w & ~pwrite;

  // Address decode
  wire hit_ctrl  = (paddr == `SWDT_A_CTRL);
  wire hit_tmo   = (paddr == `SWDT_A_TMO);
  wire hit_kick  = (paddr == `SWDT_A_KICK);
  wire hit_left  = (paddr == `SWDT_A_LEFT);
  wire hit_fault = (paddr == `SWDT_A_FAULT);
  wire hit_carry = (paddr == `SWDT_A_CARRY);
  wire hit_err   = (paddr == `SWDT_A_ERRCNT);
  wire hit_ists  = (paddr == `SWDT_A_ISTS);
  wire hit_mask  = (paddr == `SWDT_A_IMASK);
  wire mapped_w  = hit_ctrl | hit_tmo | hit_kick | hit_left | hit_fault
                 | hit_carry | hit_err | hit_ists | hit_mask;

  // Control decode; a zero timeout write is dropped so the old value stays
  wire       en_nxt    = (wr_w & hit_ctrl) ? pwdata[`SWDT_EN_BIT] : en_r;
  wire       en_rise_w = en_nxt & ~en_r;
  wire       tmo_wr_w  = wr_w & hit_tmo & (pwdata[7:0] >= `SWDT_TMO_MIN);
  wire       kick_w    = wr_w & hit_kick;
  wire       reload_w  = kick_w | en_rise_w;
  wire       expire_w  = tick & (cnt_r == `SWDT_TMO_MIN);
  wire       bark_go_w = (state_r == SWDT_COUNT) & (state_nxt == SWDT_BARK);
  wire       wrap_w    = bark_go_w & (errcnt_r == `SWDT_ERR_MAX);
  wire [1:0] ev_w      = {wrap_w, bark_go_w};

  // Write-one-clear and read-clear strobes
  wire       fault_clr = wr_w & hit_fault & pwdata[`SWDT_FAULT_BIT];
  wire       carry_clr = wr_w & hit_carry & pwdata[`SWDT_CARRY_BIT];
  // A read clears only the bits it returned: an event that lands in the first
  // access cycle is missing from prdata_r, so it must survive the clear
  wire [1:0] ists_clr  = {2{rd_w & hit_ists}} & prdata_r[1:0];

  // Prescaler runs only while counting; restarted so a reload gets full seconds
  swdt_secdiv #(
    .CYC     (SEC_CYC)
  ) u_secdiv (
    .pclk    (pclk),
    .presetn (presetn),
    .restart ((state_r != SWDT_COUNT) | reload_w),
    .tick_r  (tick)
  );

  // Countdown controller
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    blen_nxt  = blen_r;
    case (state_r)
      SWDT_IDLE: begin
        if (en_rise_w) begin
          state_nxt = SWDT_COUNT;
          cnt_nxt   = tmo_r;
        end
      end
      SWDT_COUNT: begin
        if (!en_nxt) begin
          state_nxt = SWDT_IDLE;
        end else if (reload_w) begin
          cnt_nxt = tmo_r;
        end else if (expire_w) begin
          state_nxt = SWDT_BARK;
          blen_nxt  = 3'(`SWDT_BARK_CYC - 1);
        end else if (tick) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      SWDT_BARK: begin
        // The reset pulse is finished even if software disables meanwhile
        if (blen_r != 3'h0) begin
          blen_nxt = blen_r - 3'h1;
        end else if (en_nxt) begin
          // The pending enable decides, so a late enable write never strands idle
          state_nxt = SWDT_COUNT;
          cnt_nxt   = tmo_r;
        end else begin
          state_nxt = SWDT_IDLE;
        end
      end
      default: begin
        state_nxt = SWDT_IDLE;
      end
    endcase
  end

  // Controller registers; enabled from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SWDT_COUNT;
      en_r    <= `SWDT_EN_RST;
      cnt_r   <= `SWDT_TMO_RST;
      blen_r  <= 3'h0;
      bark_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_r    <= en_nxt;
      cnt_r   <= cnt_nxt;
      blen_r  <= blen_nxt;
      bark_r  <= (state_nxt == SWDT_BARK);
    end
  end

  // Timeout and interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_r  <= `SWDT_TMO_RST;
      mask_r <= `SWDT_MASK_RST;
    end else begin
      if (tmo_wr_w) tmo_r <= pwdata[7:0];
      if (wr_w & hit_mask) mask_r <= pwdata[1:0];
    end
  end

  // Sticky flags and error counter; a new event wins over a clear or write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r  <= 1'b0;
      carry_r  <= 1'b0;
      errcnt_r <= 4'h0;
      ists_r   <= 2'h0;
    end else begin
      fault_r <= bark_go_w | (fault_r & ~fault_clr);
      carry_r <= wrap_w | (carry_r & ~carry_clr);
      if (bark_go_w) begin
        errcnt_r <= errcnt_r + 4'h1;
      end else if (wr_w & hit_err) begin
        errcnt_r <= pwdata[3:0];
      end
      ists_r <= ev_w | (ists_r & ~ists_clr);
    end
  end

  // Read data selection
  always_comb begin
    rdata_w = 32'h0000_0000;
    case (1'b1)
      hit_ctrl:  rdata_w[`SWDT_EN_BIT]    = en_r;
      hit_tmo:   rdata_w[7:0]             = tmo_r;
      hit_left:  rdata_w[7:0]             = cnt_r;
      hit_fault: rdata_w[`SWDT_FAULT_BIT] = fault_r;
      hit_carry: rdata_w[`SWDT_CARRY_BIT] = carry_r;
      hit_err:   rdata_w[3:0]             = errcnt_r;
      hit_ists:  rdata_w[1:0]             = ists_r;
      hit_mask:  rdata_w[1:0]             = mask_r;
      default:   rdata_w                  = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait state, so every output leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      pready_r  <= first_w;
      prdata_r  <= (first_w & ~pwrite) ? rdata_w : 32'h0000_0000;
      pslverr_r <= first_w & ~mapped_w;
      irq_r     <= |(ists_r & mask_r);
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign irq       = irq_r;
  assign wdt_reset = bark_r;

  // Checks
  AST_NO_BARK_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bark_r) |-> $past(en_r) && en_r)
    else $error("Bark started while disabled");

  AST_TMO_NONZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_w && hit_tmo) |=> (tmo_r != 8'h00) &&
      (tmo_r == (($past(pwdata[7:0]) != 8'h00) ? $past(pwdata[7:0]) : $past(tmo_r))))
    else $error("Timeout register took a wrong value");

  AST_BARK_ON_EXPIRY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bark_r) |-> $past(tick) && ($past(cnt_r) == 8'h01) && !$past(kick_w))
    else $error("Bark without a last-second expiry");

  AST_BARK_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bark_r) |-> bark_r [*8] ##1 !bark_r)
    else $error("Bark pulse length wrong");

  AST_ENABLED_AFTER_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> en_r && (state_r == SWDT_COUNT) && (tmo_r == 8'hFF))
    else $error("Not enabled after reset");

  AST_KICK_RELOADS: assert property (@(posedge pclk) disable iff (!presetn)
    (kick_w && state_r == SWDT_COUNT && en_nxt) |=> (cnt_r == $past(tmo_r)) && !bark_r)
    else $error("Kick did not reload the countdown");

  AST_ENABLE_RELOADS: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(en_r) && state_r == SWDT_COUNT) |-> cnt_r == tmo_r)
    else $error("Enable did not load the full timeout");

  AST_FAULT_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bark_r) |-> fault_r ##1 (fault_r || $past(fault_clr)))
    else $error("Reset-seen flag not set or lost");

  AST_ERRCNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bark_r) |-> (errcnt_r == $past(errcnt_r) + 4'h1) &&
      (($past(errcnt_r) != 4'hF) || carry_r))
    else $error("Error counter or carry wrong on bark");

  // Countdown, flag, interrupt and bus checks
  AST_DISABLE_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SWDT_COUNT && !en_nxt) |=> (state_r == SWDT_IDLE) && !bark_r)
    else $error("Disable did not stop the countdown");

  AST_SECOND_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SWDT_COUNT && en_nxt && tick && !reload_w && !expire_w)
      |=> cnt_r == $past(cnt_r) - 8'h01)
    else $error("Remaining seconds did not step by one");

  AST_BARK_RESUMES: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(bark_r) && en_r) |-> (state_r == SWDT_COUNT) && (cnt_r == $past(tmo_r)))
    else $error("Countdown not reloaded after the bark pulse");

  AST_CARRY_ON_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_w |=> carry_r && (errcnt_r == 4'h0))
    else $error("Counter wrap did not set the carry flag");

  AST_FAULT_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_clr && !bark_go_w) |=> !fault_r)
    else $error("Reset-seen flag not cleared by a write of one");

  AST_EVENT_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
    (|ev_w) |=> ((ists_r & $past(ev_w)) == $past(ev_w)))
    else $error("Event lost from the interrupt status");

  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (irq_r == |($past(ists_r) & $past(mask_r))))
    else $error("Interrupt level does not follow status and mask");

  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready_r |=> !pready_r)
    else $error("Ready stood longer than one cycle");

  AST_SLVERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (first_w && !mapped_w) |=> pslverr_r && pready_r)
    else $error("Unmapped access answered without an error");

endmodule : swdt_top

/* sim/swdt_test.sv */
// Purpose: Self-checking bench for the watchdog over APB
// Assumes: SEC_CYC shortened to 20 cycles so whole seconds pass quickly
// Notes:   Random timeouts and kick data come from a fixed-seed LFSR
`timescale 1ns/100ps
`include "swdt_defs.svh"
module swdt_test;
  import swdt_pkg::*;
  localparam int unsigned SC = 20;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        wdt_reset;
  logic        err;
  logic [15:0] lf      = 16'h8FC6;
  logic [7:0]  v;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          barks       = 0;
  int          hi          = 0;
  int          n;
  int          b0;

  swdt_top #(.SEC_CYC(SC)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .wdt_reset(wdt_reset));

  // Clock, 10 ns period
  always #5 pclk = ~pclk;

  // Every bark pulse is measured when it ends, so a stretched or cut pulse shows
  always @(posedge pclk) begin
    if (wdt_reset === 1'b1) begin
      hi <= hi + 1;
    end else if (hi != 0) begin
      chk("bark_len", hi, 32'h0000_0008);
      hi    <= 0;
      barks <= barks + 1;
    end
  end

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      bad_count++;
      print_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk($sformatf("reg_%h", a), rd, e);
    chk("slverr_ok", {31'h0, err}, 32'h0000_0000);
  endtask : rc

  // Bounded wait for a bark; c counts edges since the caller's last transfer
  task automatic wb(output int c);
    c = 0;
    while (wdt_reset !== 1'b1 && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 2000) begin
      bad_count++;
      print_verdict();
    end
  endtask : wb

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(`SWDT_A_LEFT, 32'h0000_00FF);
    rc(`SWDT_A_CTRL, 32'h0000_0001);
    rc(`SWDT_A_TMO, 32'h0000_00FF);
    rc(`SWDT_A_FAULT, 32'h0000_0000);
    rc(`SWDT_A_ERRCNT, 32'h0000_0000);
    rc(`SWDT_A_CARRY, 32'h0000_0000);
    rc(`SWDT_A_IMASK, 32'h0000_0000);
    apb(8'h24, 1'b0, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    // Random legal timeouts, then a zero that must leave the last one
    repeat (4) begin
      lf = nx(lf);
      v  = (lf[7:0] == 8'h00) ? 8'h01 : lf[7:0];
      wr(`SWDT_A_TMO, {24'h0, v});
      rc(`SWDT_A_TMO, {24'h0, v});
    end
    wr(`SWDT_A_TMO, 32'h0000_0000);
    rc(`SWDT_A_TMO, {24'h0, v});
    // Kicks with random data, each inside the 2 s window, keep it quiet
    wr(`SWDT_A_TMO, 32'h0000_0002);
    wr(`SWDT_A_IMASK, 32'h0000_0003);
    b0 = barks;
    repeat (6) begin
      lf = nx(lf);
      wr(`SWDT_A_KICK, {lf, ~lf});
      rc(`SWDT_A_LEFT, 32'h0000_0002);
      repeat (20) @(posedge pclk);
    end
    chk("quiet", barks, b0);
    // No kick: bark lands two seconds after the last one
    wr(`SWDT_A_KICK, 32'h0000_0000);
    wb(n);
    chk("bark_at", {31'h0, n >= 2 * SC - 2 && n <= 2 * SC + 6}, 32'h0000_0001);
    wr(`SWDT_A_CTRL, 32'h0000_0000);
    repeat (12) @(posedge pclk);
    chk("irq_on", {31'h0, irq}, 32'h0000_0001);
    rc(`SWDT_A_FAULT, 32'h0000_0004);
    rc(`SWDT_A_ERRCNT, 32'h0000_0001);
    rc(`SWDT_A_ISTS, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk("irq_off", {31'h0, irq}, 32'h0000_0000);
    wr(`SWDT_A_FAULT, 32'h0000_0004);
    rc(`SWDT_A_FAULT, 32'h0000_0000);
    // Counter at its top value wraps on the next bark and sets carry
    wr(`SWDT_A_ERRCNT, 32'h0000_000F);
    wr(`SWDT_A_CTRL, 32'h0000_0001);
    rc(`SWDT_A_LEFT, 32'h0000_0002);
    wb(n);
    wr(`SWDT_A_CTRL, 32'h0000_0000);
    repeat (12) @(posedge pclk);
    rc(`SWDT_A_ERRCNT, 32'h0000_0000);
    rc(`SWDT_A_CARRY, 32'h0000_0004);
    rc(`SWDT_A_ISTS, 32'h0000_0003);
    wr(`SWDT_A_CARRY, 32'h0000_0004);
    rc(`SWDT_A_CARRY, 32'h0000_0000);
    // Disabled: far past the timeout and still no bark
    b0 = barks;
    repeat (200) @(posedge pclk);
    chk("idle", barks, b0);
    // Left enabled: after the pulse the countdown restarts in full and barks again
    wr(`SWDT_A_CTRL, 32'h0000_0001);
    wb(n);
    repeat (12) @(posedge pclk);
    rc(`SWDT_A_LEFT, 32'h0000_0002);
    wb(n);
    wr(`SWDT_A_CTRL, 32'h0000_0000);
    repeat (12) @(posedge pclk);
    rc(`SWDT_A_ERRCNT, 32'h0000_0002);
    // Masked out: the event is recorded but irq stays low
    wr(`SWDT_A_IMASK, 32'h0000_0000);
    wr(`SWDT_A_CTRL, 32'h0000_0001);
    wb(n);
    wr(`SWDT_A_CTRL, 32'h0000_0000);
    repeat (12) @(posedge pclk);
    chk("irq_mask", {31'h0, irq}, 32'h0000_0000);
    rc(`SWDT_A_ISTS, 32'h0000_0001);
    print_verdict();
  end
endmodule : swdt_test
